// [nfc_pkg.sv]
package nfc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_MHZ = 40;
  localparam int ACC_NS = 55;
  localparam int ACC_CYC = (ACC_NS * CLK_MHZ) / 1000;
  localparam int RDY_BUSY_US = 35;
  localparam int RDY_BUSY_CYC = RDY_BUSY_US * CLK_MHZ;
  localparam int RDY_IDLE_NS = 500;
  localparam int RDY_IDLE_CYC = (RDY_IDLE_NS * CLK_MHZ) / 1000;
  localparam int RST_ABORT_CYC = 4;

  // ****************************************************************
  // Array and embedded operation
  // ****************************************************************
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int UNLOCK_W = 12;
  localparam int SECT_LSB = 12;
  localparam int PROG_CYC = 16;
  localparam int PREPROG_CYC = 8;
  localparam int ERASE_CYC = 32;

  // ****************************************************************
  // Command words and unlock addresses
  // ****************************************************************
  localparam logic [11:0] UNLOCK_A1 = 12'h555;
  localparam logic [11:0] UNLOCK_A2 = 12'h2AA;
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [15:0] PREPROG_WORD = 16'h0000;

  typedef enum logic [2:0] {
    NFC_SEQ_IDLE = 3'b000,
    NFC_SEQ_U1 = 3'b001,
    NFC_SEQ_CMD = 3'b010,
    NFC_SEQ_PDATA = 3'b011,
    NFC_SEQ_EU0 = 3'b100,
    NFC_SEQ_EU1 = 3'b101,
    NFC_SEQ_EU2 = 3'b110
  } nfc_seq_t;

  typedef enum logic [1:0] {
    NFC_OP_NONE = 2'b00,
    NFC_OP_PROG = 2'b01,
    NFC_OP_SECT = 2'b10,
    NFC_OP_CHIP = 2'b11
  } nfc_op_t;

endpackage

// [nfc_sync2.sv]
`timescale 1ns/1ps

// Two-stage synchroniser for pin levels.
module nfc_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock, // System clock.
  input wire logic sys_rst, // Synchronous reset.
  input wire logic [W-1:0] d, // Asynchronous level.
  output logic [W-1:0] q // Synchronised level.
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = sys_rst ? INIT : d;
    q_nxt = sys_rst ? INIT : meta_r;
  end

  always_ff @(posedge clock) begin
    meta_r <= meta_nxt;
    q_r <= q_nxt;
  end

  assign q = q_r;

endmodule

// [nfc_core.sv]
`timescale 1ns/1ps

module nfc_core #(
  parameter int WORDS = 256, // Modelled array depth.
  parameter int BUSY_CYC = nfc_pkg::RDY_BUSY_CYC // Standby threshold basis, cycles (standby after half of it).
) (
  input wire logic clock, // System clock.
  input wire logic sys_rst, // Synchronous reset.
  input wire logic chip_sel_n, // Chip select pin.
  input wire logic address_latch_strobe_n, // Address latch strobe pin.
  input wire logic write_n, // Write strobe pin.
  input wire logic out_en_n, // Output gate pin.
  input wire logic hw_reset_n, // Hardware reset pin.
  input wire logic flash_clk, // Device clock pin, sampled.
  input wire logic sync_read_mode, // Read-mode select bit.
  input wire logic [nfc_pkg::ADDR_W-1:0] addr, // Address pins.
  input wire logic [nfc_pkg::DATA_W-1:0] dq_in, // Data pins, input.
  output logic [nfc_pkg::DATA_W-1:0] dq_out, // Data pins, output.
  output logic dq_oe, // Data output enable.
  output logic ready, // Ready pin.
  output logic standby // High while in reset standby.
);

  localparam int AW = $clog2(WORDS);

  logic cs_n, strb_n, we_n, oe_n, rst_n, fclk;
  logic [nfc_pkg::ADDR_W-1:0] a_s;
  logic [nfc_pkg::DATA_W-1:0] d_s;

  nfc_sync2 #(.W(6), .INIT(6'h3E)) u_pins (
    .clock(clock),
    .sys_rst(sys_rst),
    .d({chip_sel_n, address_latch_strobe_n, write_n, out_en_n, hw_reset_n, flash_clk}),
    .q({cs_n, strb_n, we_n, oe_n, rst_n, fclk})
  );

  nfc_sync2 #(.W(nfc_pkg::ADDR_W + nfc_pkg::DATA_W)) u_bus (
    .clock(clock),
    .sys_rst(sys_rst),
    .d({addr, dq_in}),
    .q({a_s, d_s})
  );

  // ****************************************************************
  // Edge detection and address capture
  // ****************************************************************
  logic strb_d_r, we_d_r, clk_d_r, cs_d_r;
  logic strb_rise, strb_fall, we_fall, we_rise, clk_rise, cs_rise;
  logic [nfc_pkg::ADDR_W-1:0] a_d_r, lat_a_r, lat_a_nxt;
  logic lat_ok_r, lat_ok_nxt;

  assign strb_rise = ~strb_d_r & strb_n;
  assign strb_fall = strb_d_r & ~strb_n;
  assign we_fall = we_d_r & ~we_n;
  assign we_rise = ~we_d_r & we_n;
  assign clk_rise = ~clk_d_r & fclk;
  assign cs_rise = ~cs_d_r & cs_n;

  always_comb begin
    lat_a_nxt = lat_a_r;
    lat_ok_nxt = lat_ok_r;
    if (cs_rise || strb_fall) begin
      lat_ok_nxt = 1'b0;
    end
    if (!cs_n && sync_read_mode && !lat_ok_r && !strb_n && clk_rise) begin
      lat_a_nxt = a_s;
      lat_ok_nxt = 1'b1;
    end else if (!cs_n && !lat_ok_r && strb_rise) begin
      lat_a_nxt = a_d_r;
      lat_ok_nxt = 1'b1;
    end else if (!cs_n && strb_n && we_fall) begin
      lat_a_nxt = a_s;
      lat_ok_nxt = 1'b1;
    end
    if (sys_rst) begin
      lat_a_nxt = '0;
      lat_ok_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    strb_d_r <= strb_n;
    we_d_r <= we_n;
    clk_d_r <= fclk;
    cs_d_r <= cs_n;
    a_d_r <= a_s;
    lat_a_r <= lat_a_nxt;
    lat_ok_r <= lat_ok_nxt;
  end

  // ****************************************************************
  // Command decoder and embedded operation
  // ****************************************************************
  nfc_pkg::nfc_seq_t seq_r, seq_nxt;
  nfc_pkg::nfc_op_t op_r, op_nxt;
  localparam int DATA_W_L = nfc_pkg::DATA_W;
  logic [DATA_W_L-1:0] mem_r [WORDS];
  logic [nfc_pkg::ADDR_W-1:0] op_a_r, op_a_nxt;
  logic [DATA_W_L-1:0] op_d_r, op_d_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic pre_r, pre_nxt;
  logic [15:0] rst_cnt_r, rst_cnt_nxt;
  logic abort_r, abort_nxt;
  logic [20:0] lowt_r, lowt_nxt;
  logic wr_ok, unl1, unl2, done;
  logic [11:0] lo;
  logic [7:0] cmd;

  assign lo = lat_a_r[nfc_pkg::UNLOCK_W-1:0];
  assign cmd = d_s[7:0];
  assign wr_ok = we_rise && !cs_n && rst_n && op_r == nfc_pkg::NFC_OP_NONE;
  assign unl1 = lo == nfc_pkg::UNLOCK_A1 && cmd == nfc_pkg::CMD_UNLOCK1;
  assign unl2 = lo == nfc_pkg::UNLOCK_A2 && cmd == nfc_pkg::CMD_UNLOCK2;
  assign done = op_r != nfc_pkg::NFC_OP_NONE && cnt_r == 16'h0000;

  always_comb begin
    seq_nxt = seq_r;
    op_nxt = op_r;
    op_a_nxt = op_a_r;
    op_d_nxt = op_d_r;
    cnt_nxt = (cnt_r != 16'h0000) ? cnt_r - 16'h0001 : cnt_r;
    pre_nxt = pre_r;
    abort_nxt = abort_r;
    rst_cnt_nxt = rst_cnt_r;
    lowt_nxt = rst_n ? 21'h000000 : (lowt_r == 21'h1FFFFF ? lowt_r : lowt_r + 21'h000001);
    if (wr_ok) begin
      seq_nxt = nfc_pkg::NFC_SEQ_IDLE;
      if (cmd == nfc_pkg::CMD_RESET) begin
        seq_nxt = nfc_pkg::NFC_SEQ_IDLE;
      end else begin
        unique case (seq_r)
          nfc_pkg::NFC_SEQ_IDLE: if (unl1) seq_nxt = nfc_pkg::NFC_SEQ_U1;
          nfc_pkg::NFC_SEQ_U1: if (unl2) seq_nxt = nfc_pkg::NFC_SEQ_CMD;
          nfc_pkg::NFC_SEQ_CMD: begin
            if (lo == nfc_pkg::UNLOCK_A1 && cmd == nfc_pkg::CMD_PROGRAM) begin
              seq_nxt = nfc_pkg::NFC_SEQ_PDATA;
            end else if (lo == nfc_pkg::UNLOCK_A1 && cmd == nfc_pkg::CMD_ERASE) begin
              seq_nxt = nfc_pkg::NFC_SEQ_EU0;
            end
          end
          nfc_pkg::NFC_SEQ_PDATA: begin
            op_nxt = nfc_pkg::NFC_OP_PROG;
            op_a_nxt = lat_a_r;
            op_d_nxt = d_s;
            cnt_nxt = 16'(nfc_pkg::PROG_CYC);
          end
          nfc_pkg::NFC_SEQ_EU0: if (unl1) seq_nxt = nfc_pkg::NFC_SEQ_EU1;
          nfc_pkg::NFC_SEQ_EU1: if (unl2) seq_nxt = nfc_pkg::NFC_SEQ_EU2;
          nfc_pkg::NFC_SEQ_EU2: begin
            pre_nxt = 1'b1;
            cnt_nxt = 16'(nfc_pkg::PREPROG_CYC);
            op_a_nxt = lat_a_r;
            if (lo == nfc_pkg::UNLOCK_A1 && cmd == nfc_pkg::CMD_CHIP) begin
              op_nxt = nfc_pkg::NFC_OP_CHIP;
            end else if (cmd == nfc_pkg::CMD_SECTOR) begin
              op_nxt = nfc_pkg::NFC_OP_SECT;
            end else begin
              pre_nxt = 1'b0;
            end
          end
          default: seq_nxt = nfc_pkg::NFC_SEQ_IDLE;
        endcase
      end
    end
    if (done && pre_r) begin
      pre_nxt = 1'b0;
      cnt_nxt = 16'(nfc_pkg::ERASE_CYC);
    end else if (done) begin
      op_nxt = nfc_pkg::NFC_OP_NONE;
    end
    if (!rst_n) begin
      seq_nxt = nfc_pkg::NFC_SEQ_IDLE;
      if (op_r != nfc_pkg::NFC_OP_NONE && !abort_r) begin
        abort_nxt = 1'b1;
        rst_cnt_nxt = 16'(nfc_pkg::RST_ABORT_CYC);
      end
      if (abort_r && rst_cnt_r == 16'h0000) begin
        op_nxt = nfc_pkg::NFC_OP_NONE;
        pre_nxt = 1'b0;
        abort_nxt = 1'b0;
      end else if (abort_r) begin
        rst_cnt_nxt = rst_cnt_r - 16'h0001;
      end
    end
    if (sys_rst) begin
      seq_nxt = nfc_pkg::NFC_SEQ_IDLE;
      op_nxt = nfc_pkg::NFC_OP_NONE;
      op_a_nxt = '0;
      op_d_nxt = '0;
      cnt_nxt = 16'h0000;
      pre_nxt = 1'b0;
      abort_nxt = 1'b0;
      rst_cnt_nxt = 16'h0000;
      lowt_nxt = 21'h000000;
    end
  end

  always_ff @(posedge clock) begin
    seq_r <= seq_nxt;
    op_r <= op_nxt;
    op_a_r <= op_a_nxt;
    op_d_r <= op_d_nxt;
    cnt_r <= cnt_nxt;
    pre_r <= pre_nxt;
    abort_r <= abort_nxt;
    rst_cnt_r <= rst_cnt_nxt;
    lowt_r <= lowt_nxt;
  end

  // Array update happens only when the operation completes normally.
  always_ff @(posedge clock) begin
    for (int i = 0; i < WORDS; i++) begin
      if (done && !pre_r && rst_n) begin
        if (op_r == nfc_pkg::NFC_OP_PROG && op_a_r[AW-1:0] == AW'(i)) begin
          mem_r[i] <= mem_r[i] & op_d_r;
        end else if (op_r == nfc_pkg::NFC_OP_CHIP) begin
          mem_r[i] <= nfc_pkg::ERASED_WORD;
        end else if (op_r == nfc_pkg::NFC_OP_SECT && (AW <= nfc_pkg::SECT_LSB)) begin
          mem_r[i] <= nfc_pkg::ERASED_WORD;
        end
      end
    end
  end

  // ****************************************************************
  // Asynchronous read path and pin outputs
  // ****************************************************************
  logic [15:0] acc_r, acc_nxt;
  logic [nfc_pkg::ADDR_W-1:0] rd_a;
  logic [DATA_W_L-1:0] dq_out_r, dq_out_nxt;
  logic dq_oe_r, dq_oe_nxt, ready_r, ready_nxt, standby_r, standby_nxt;

  assign rd_a = strb_n ? lat_a_r : a_s;

  always_comb begin
    acc_nxt = acc_r;
    if (strb_fall || a_s != a_d_r || cs_rise) begin
      acc_nxt = 16'(nfc_pkg::ACC_CYC);
    end else if (acc_r != 16'h0000) begin
      acc_nxt = acc_r - 16'h0001;
    end
    dq_oe_nxt = !cs_n && !oe_n && we_n && rst_n;
    dq_out_nxt = dq_out_r;
    if (acc_r == 16'h0000 || acc_r == 16'h0001) begin
      dq_out_nxt = (op_r == nfc_pkg::NFC_OP_NONE) ? mem_r[rd_a[AW-1:0]] : 16'h0000;
    end
    ready_nxt = (op_r == nfc_pkg::NFC_OP_NONE) || sync_read_mode;
    standby_nxt = lowt_r >= 21'(BUSY_CYC / 2);
    if (sys_rst) begin
      acc_nxt = 16'h0000;
      dq_oe_nxt = 1'b0;
      dq_out_nxt = '0;
      ready_nxt = 1'b1;
      standby_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    acc_r <= acc_nxt;
    dq_out_r <= dq_out_nxt;
    dq_oe_r <= dq_oe_nxt;
    ready_r <= ready_nxt;
    standby_r <= standby_nxt;
  end

  assign dq_out = dq_out_r;
  assign dq_oe = dq_oe_r;
  assign ready = ready_r;
  assign standby = standby_r;

endmodule

// [nfc_core_assertions.sv]
`timescale 1ns/1ps
module nfc_core_chk #(
  parameter int BUSY_CYC = 40 // Standby threshold basis.
) (
  input wire logic clock, // Clock.
  input wire logic sys_rst, // Reset.
  input wire logic chip_sel_n, // Pin.
  input wire logic out_en_n, // Pin.
  input wire logic hw_reset_n, // Pin.
  input wire logic sync_read_mode, // Mode bit.
  input wire logic dq_oe, // Drive.
  input wire logic ready, // Busy flag.
  input wire logic standby // Standby.
);
  localparam int OP_MAX = 64;
  localparam int ABORT_MAX = 16;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  property p_op_len;
    $fell(ready) && hw_reset_n && !sync_read_mode |-> !ready [*8];
  endproperty
  a_op_len: assert property (p_op_len)
    else $error("busy phase too short");
  property p_op_end;
    $fell(ready) |-> ##[1:OP_MAX] ready;
  endproperty
  a_op_end: assert property (p_op_end)
    else $error("busy phase never ended");
  property p_abort;
    $fell(hw_reset_n) && !ready |-> ##[1:ABORT_MAX] ready;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort too slow");
  property p_idle;
    !hw_reset_n [*8] |-> ##3 ready;
  endproperty
  a_idle: assert property (p_idle)
    else $error("no read mode in reset");
  property p_idle_keep;
    $fell(hw_reset_n) && ready |-> ready [*6];
  endproperty
  a_idle_keep: assert property (p_idle_keep)
    else $error("ready dropped in reset");
  property p_stby_in;
    $rose(standby) |-> !$past(hw_reset_n, BUSY_CYC / 2);
  endproperty
  a_stby_in: assert property (p_stby_in)
    else $error("standby too early");
  property p_stby_out;
    hw_reset_n [*5] |-> !standby;
  endproperty
  a_stby_out: assert property (p_stby_out)
    else $error("standby kept");
  property p_oe_off;
    out_en_n [*4] |-> !dq_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("driving with gate off");
  property p_oe_on;
    (!chip_sel_n && !out_en_n && hw_reset_n) [*5] |-> dq_oe;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("not driving read data");
  c_busy: cover property ($fell(ready));
  c_abort: cover property ($fell(hw_reset_n) && !ready);
  c_stby: cover property ($rose(standby));
endmodule

bind nfc_core nfc_core_chk #(.BUSY_CYC(BUSY_CYC)) i_chk (
  .clock(clock), .sys_rst(sys_rst), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
  .hw_reset_n(hw_reset_n), .sync_read_mode(sync_read_mode), .dq_oe(dq_oe),
  .ready(ready), .standby(standby)
);

// [nfc_host.sv]
`timescale 1ns/1ps
module nfc_host (
  input wire logic clock, // Clock.
  input wire logic [15:0] dq_out, // Read data.
  input wire logic dq_oe, // Drive.
  output logic chip_sel_n, // Pin.
  output logic address_latch_strobe_n, // Pin.
  output logic write_n, // Pin.
  output logic out_en_n, // Pin.
  output logic hw_reset_n, // Pin.
  output logic flash_clk, // Pin.
  output logic [22:0] addr, // Pins.
  output logic [15:0] dq_in // Pins.
);
  initial begin
    {chip_sel_n, address_latch_strobe_n, write_n, out_en_n, hw_reset_n} = 5'h1F;
    flash_clk = 1'h0;
    addr = 23'h000000;
    dq_in = 16'h0000;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wr(input logic [22:0] a, input logic [15:0] d, input bit syn, input bit wl);
    {chip_sel_n, address_latch_strobe_n} = {1'h0, wl};
    addr = a;
    dq_in = d;
    tick(1);
    flash_clk = syn;
    tick(1);
    flash_clk = 1'h0;
    {address_latch_strobe_n, write_n} = 2'h2;
    tick(2);
    write_n = 1'h1;
    tick(1);
    chip_sel_n = 1'h1;
    addr = ~a;
    dq_in = ~d;
    tick(2);
  endtask
  task automatic rd(input logic [22:0] a, input bit g, output logic [15:0] d, output logic oe);
    {chip_sel_n, address_latch_strobe_n} = 2'h0;
    out_en_n = g;
    addr = a;
    tick(1);
    address_latch_strobe_n = 1'h1;
    tick(nfc_pkg::ACC_CYC + 5);
    d = dq_out;
    oe = dq_oe;
    {chip_sel_n, out_en_n} = 2'h3;
    addr = ~a;
    tick(2);
  endtask
  task automatic rst(input logic lvl, input int n);
    hw_reset_n = lvl;
    tick(n);
  endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic sync_read_mode = 1'h0;
  logic chip_sel_n, address_latch_strobe_n, write_n, out_en_n, hw_reset_n, flash_clk;
  logic [22:0] addr;
  logic [15:0] dq_in, dq_out;
  logic dq_oe, ready, standby;
  logic [15:0] mem [int];
  logic [31:0] seed = 32'h00008E1D;
  int fail_count = 0;
  int compares = 0;
  initial begin
    forever #12.5 clock = ~clock;
  end
  nfc_core #(.BUSY_CYC(40)) i_dut (
    .clock(clock), .sys_rst(sys_rst), .chip_sel_n(chip_sel_n),
    .address_latch_strobe_n(address_latch_strobe_n), .write_n(write_n),
    .out_en_n(out_en_n), .hw_reset_n(hw_reset_n), .flash_clk(flash_clk),
    .sync_read_mode(sync_read_mode), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .ready(ready), .standby(standby)
  );
  nfc_host i_host (
    .clock(clock), .dq_out(dq_out), .dq_oe(dq_oe), .chip_sel_n(chip_sel_n),
    .address_latch_strobe_n(address_latch_strobe_n), .write_n(write_n),
    .out_en_n(out_en_n), .hw_reset_n(hw_reset_n), .flash_clk(flash_clk),
    .addr(addr), .dq_in(dq_in)
  );
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic summarize();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [22:0] a, input logic [7:0] c, input bit syn);
    i_host.wr(a, {8'h00, c}, syn, 1'(rnd()));
  endtask
  task automatic unlock(input bit syn);
    cmd({11'(rnd()), nfc_pkg::UNLOCK_A1}, nfc_pkg::CMD_UNLOCK1, syn);
    cmd({11'(rnd()), nfc_pkg::UNLOCK_A2}, nfc_pkg::CMD_UNLOCK2, syn);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    i_host.tick(3);
    chk({15'h0000, ready}, {15'h0000, sync_read_mode});
    while (ready !== 1'h1 && n < 200) begin
      i_host.tick(1);
      n++;
    end
    chk({15'h0000, ready}, 16'h0001);
    i_host.tick(24);
  endtask
  task automatic check(input logic [7:0] a);
    logic [15:0] d;
    logic oe;
    bit g;
    g = 1'(rnd());
    i_host.rd({15'h0000, a}, g, d, oe);
    chk({15'h0000, oe}, {15'h0000, ~g});
    chk(d, mem[a]);
  endtask
  task automatic prog(input logic [7:0] a, input logic [15:0] d, input bit syn);
    unlock(syn);
    cmd({11'h000, nfc_pkg::UNLOCK_A1}, nfc_pkg::CMD_PROGRAM, syn);
    i_host.wr({15'h0000, a}, d, syn, 1'(rnd()));
    wait_done();
    mem[a] = mem[a] & d;
  endtask
  task automatic erase(input bit chip);
    unlock(1'h0);
    cmd({11'h000, nfc_pkg::UNLOCK_A1}, nfc_pkg::CMD_ERASE, 1'h0);
    unlock(1'h0);
    if (chip) begin
      cmd({11'h000, nfc_pkg::UNLOCK_A1}, nfc_pkg::CMD_CHIP, 1'h0);
    end else begin
      cmd({11'(rnd()), 12'h000}, nfc_pkg::CMD_SECTOR, 1'h0);
    end
    wait_done();
    for (int i = 0; i < 256; i++) begin
      mem[i] = nfc_pkg::ERASED_WORD;
    end
  endtask
  initial begin
    #(40000 * 25);
    fail_count++;
    summarize();
  end
  initial begin
    logic [7:0] a;
    bit s;
    i_host.tick(5);
    sys_rst = 1'h0;
    i_host.tick(3);
    erase(1'h1);
    for (int i = 0; i < 256; i += 51) begin
      check(8'(i));
    end
    $display("chip erase test done");
    for (int i = 0; i < 12; i++) begin
      s = 1'(rnd());
      sync_read_mode = s;
      a = 8'(rnd());
      prog(a, 16'(rnd()), s & i[0]);
      prog(a, 16'(rnd()), 1'h0);
      check(a);
    end
    $display("program test done");
    sync_read_mode = 1'h0;
    erase(1'h0);
    check(a);
    $display("sector erase test done");
    unlock(1'h0);
    cmd({11'h000, nfc_pkg::UNLOCK_A1}, nfc_pkg::CMD_PROGRAM, 1'h0);
    i_host.wr(23'h000020, 16'h0000, 1'h0, 1'h1);
    i_host.tick(4);
    i_host.rst(1'h0, 12);
    chk({15'h0000, ready}, 16'h0001);
    i_host.rst(1'h1, 10);
    check(8'h20);
    i_host.rst(1'h0, 30);
    chk({15'h0000, standby}, 16'h0001);
    chk({15'h0000, ready}, 16'h0001);
    i_host.rst(1'h1, 10);
    chk({15'h0000, standby}, 16'h0000);
    check(8'h21);
    $display("reset test done");
    summarize();
  end
endmodule
